/* logic/mcma_pkg.sv */
// constants, encodings and carriers for the macrocell mode array
`default_nettype none
package mcma_pkg;
    // geometry
    localparam int CELLS      = 8;
    localparam int DED_PINS   = 8;
    localparam int PTERMS     = 8;
    localparam int ADDR_W     = 4;
    localparam int DATA_W     = 32;
    localparam int ARRAY_W    = 18;
    // register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFFSET     = 4'h0;
    localparam logic [ADDR_W-1:0] CELL_CFG_OFFSET = 4'h4;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET   = 4'h8;
    // field positions
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_POWER_DOWN_BIT = 4;
    localparam int CFG_W          = 2;
    localparam int STATUS_POWER_DOWN_BIT = 8;
    localparam int STATUS_OE_LSB  = 16;
    // reset values: every cell starts as an input, driver off
    localparam logic [1:0]  MODE_RESET     = 2'h0;
    localparam logic [15:0] CELL_CFG_RESET = 16'haaaa;
    // pin positions
    localparam int POWER_DOWN_PIN_BIT = 2;
    localparam int ARRAY_PIN1_BIT = 8;
    localparam int ARRAY_PIN11_BIT = 9;
    localparam int ARRAY_FB_LSB   = 10;
    localparam int OUTER_LO_CELL  = 0;
    localparam int OUTER_HI_CELL  = 7;
    localparam int CENTRE_LO_CELL = 3;
    localparam int CENTRE_HI_CELL = 4;
    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {MODE_REGISTERED, MODE_COMPLEX, MODE_SIMPLE} mcma_mode_type;
    typedef enum logic [1:0] {CELL_REGISTERED, CELL_COMBINATORIAL, CELL_INPUT} mcma_cell_type;

    // what one macrocell presents to its pin and to the array
    typedef struct packed {
        logic drive;
        logic enable;
        logic feedback;
        logic feedbackValid;
    } mcma_cell_out_type;
endpackage
`default_nettype wire

/* logic/mcma_macrocell_array.sv */
// eight configurable output macrocells with three architecture modes
// Functional notes
// - registered mode: pin 1 is common clock, pin 11 common output enable.
// - complex mode: pins 1, 11 are array inputs; pins 19, 12 lose feedback.
// - simple mode: centre pins 15, 16 have no feedback, always-enabled outputs.
// - registered cell: clocked by clock pin, enabled by enable pin, eight terms.
// - registered-mode combinatorial cell: one term enables, seven terms summed.
// - a cell configured as input never drives its pin, except the centre cells in simple mode and the outer cells in complex mode.
// - registered mode: each cell registered, combinatorial or input.
// - complex mode: pins 13 to 18 feed pin values back to the array.
// - complex mode: pins 12 and 19 are outputs only, no array input.
// - complex mode: seven terms summed, one term drives the enable.
// - simple mode: eight terms summed; pins 1 and 11 are array inputs.
// - simple mode: other cells are inputs or outputs with pin feedback.
// - with power-down enabled, pin 4 is no longer an array input.
// - during power-down inputs are blocked, all states and outputs held.
// - reset clears every register, so registered outputs read high.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module mcma_macrocell_array
(
    // clock and reset
    input  wire logic                                         clock,
    input  wire logic                                         nrst,
    // axi4-lite write channels
    input  wire logic [mcma_pkg::ADDR_W-1:0]                  awaddr,
    input  wire logic                                         awvalid,
    output logic                                              awready,
    input  wire logic [mcma_pkg::DATA_W-1:0]                  wdata,
    input  wire logic [3:0]                                   wstrb,
    input  wire logic                                         wvalid,
    output logic                                              wready,
    output logic [1:0]                                        bresp,
    output logic                                              bvalid,
    input  wire logic                                         bready,
    // axi4-lite read channels
    input  wire logic [mcma_pkg::ADDR_W-1:0]                  araddr,
    input  wire logic                                         arvalid,
    output logic                                              arready,
    output logic [mcma_pkg::DATA_W-1:0]                       rdata,
    output logic [1:0]                                        rresp,
    output logic                                              rvalid,
    input  wire logic                                         rready,
    // device pins
    input  wire logic                                         clockPin,
    input  wire logic                                         outputEnablePinN,
    input  wire logic [mcma_pkg::DED_PINS-1:0]                dedicatedPins,
    input  wire logic [mcma_pkg::CELLS-1:0]                   ioPinIn,
    output logic [mcma_pkg::CELLS-1:0]                        ioPinOut,
    output logic [mcma_pkg::CELLS-1:0]                        ioPinOe,
    // and-array side
    input  wire logic [mcma_pkg::CELLS-1:0][mcma_pkg::PTERMS-1:0] productTerms,
    output logic [mcma_pkg::ARRAY_W-1:0]                      arrayIn,
    output logic [mcma_pkg::ARRAY_W-1:0]                      arrayInValid
);
    import mcma_pkg::*;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    localparam int SYNC_W = 2 + DED_PINS + CELLS;

    logic [1:0]               modeBits;
    logic                     powerDownEnable;
    logic [CFG_W*CELLS-1:0]   cellCfg;
    logic [SYNC_W-1:0]        pinMeta;
    logic [SYNC_W-1:0]        pinSync;
    logic                     clockSync;
    logic                     oeSyncN;
    logic [DED_PINS-1:0]      dedSync;
    logic [CELLS-1:0]         ioSync;
    logic                     clockPrev;
    logic                     clockRise;
    logic                     powerDownActive;
    logic [CELLS-1:0]         regQ;
    mcma_mode_type            modeSel;
    mcma_cell_type            cellSel [CELLS];
    mcma_cell_out_type        next_cell [CELLS];
    logic [ARRAY_W-1:0]       next_arrayIn;
    logic [ARRAY_W-1:0]       next_arrayValid;
    logic [DED_PINS-1:0]      dedValid;
    logic                     writeHit;
    logic                     writeMapped;
    logic                     readMapped;
    logic [DATA_W-1:0]        readValue;

    // every pin is asynchronous to clock, so two stages before any use
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            pinMeta <= '0;
            pinSync <= '0;
        end
        else
        begin
            pinMeta <= {clockPin, outputEnablePinN, dedicatedPins, ioPinIn};
            pinSync <= pinMeta;
        end
    end

    assign {clockSync, oeSyncN, dedSync, ioSync} = pinSync;

    // edge detect looks at the second stage only
    always_ff @(posedge clock)
    begin
        if (!nrst)
            clockPrev <= 1'b0;
        else
            clockPrev <= clockSync;
    end

    assign clockRise = clockSync & ~clockPrev;
    assign powerDownActive = powerDownEnable & dedSync[POWER_DOWN_PIN_BIT];

    // mode decode; the spare code falls back to registered
    always_comb
    begin
        case (modeBits)
            2'h1:    modeSel = MODE_COMPLEX;
            2'h2:    modeSel = MODE_SIMPLE;
            default: modeSel = MODE_REGISTERED;
        endcase
    end

    // one macrocell's pin drive, enable and feedback for the current mode
    function automatic mcma_cell_out_type decodeCell(
        input mcma_mode_type     mode,
        input mcma_cell_type     cfg,
        input logic [PTERMS-1:0] terms,
        input logic              regBit,
        input logic              pinBit,
        input logic              oeN,
        input logic              outer,
        input logic              centre);
        mcma_cell_out_type c;
        c               = '0;
        c.feedback      = pinBit;
        c.feedbackValid = 1'b1;
        unique case (mode)
            MODE_REGISTERED:
            begin
                case (cfg)
                    CELL_REGISTERED:
                    begin
                        c.drive    = ~regBit;
                        c.enable   = ~oeN;
                        c.feedback = regBit;
                    end
                    CELL_COMBINATORIAL:
                    begin
                        c.drive  = |terms[PTERMS-1:1];
                        c.enable = terms[0];
                    end
                    default: c.enable = 1'b0;
                endcase
            end
            MODE_COMPLEX:
            begin
                c.drive  = |terms[PTERMS-1:1];
                c.enable = (cfg == CELL_INPUT && !outer) ? 1'b0 : terms[0];
                // outer feedback slots are marked invalid; pins 1 and 11 have their own slots
                // inner cells feed their pins back
                c.feedbackValid = ~outer;
            end
            MODE_SIMPLE:
            begin
                c.drive = |terms;
                // centre cells always driven, no feedback
                // others are inputs or outputs with feedback
                c.enable        = centre ? 1'b1 : (cfg != CELL_INPUT);
                c.feedbackValid = ~centre;
            end
        endcase
        return c;
    endfunction

    genvar k;
    generate
        for (k = 0; k < CELLS; k++)
        begin : g_cell
            localparam logic OUTER  = (k == OUTER_LO_CELL) || (k == OUTER_HI_CELL);
            localparam logic CENTRE = (k == CENTRE_LO_CELL) || (k == CENTRE_HI_CELL);

            // spare configuration code acts as input, the safe choice
            always_comb
            begin
                case (cellCfg[CFG_W*k +: CFG_W])
                    2'h0:    cellSel[k] = CELL_REGISTERED;
                    2'h1:    cellSel[k] = CELL_COMBINATORIAL;
                    default: cellSel[k] = CELL_INPUT;
                endcase
            end

            assign next_cell[k] = decodeCell(modeSel, cellSel[k], productTerms[k],
                                             regQ[k], ioSync[k], oeSyncN, OUTER, CENTRE);

            // capture on the clock pin rising edge
            always_ff @(posedge clock)
            begin
                if (!nrst)
                    regQ[k] <= 1'b0;
                else if (!powerDownActive && clockRise && modeSel == MODE_REGISTERED
                         && cellSel[k] == CELL_REGISTERED)
                    regQ[k] <= |productTerms[k];
            end

            assign next_arrayIn[ARRAY_FB_LSB + k]    = next_cell[k].feedback;
            assign next_arrayValid[ARRAY_FB_LSB + k] = next_cell[k].feedbackValid;
        end
    endgenerate

    // power-down pin drops out of the array when enabled
    always_comb
    begin
        dedValid             = '1;
        dedValid[POWER_DOWN_PIN_BIT] = ~powerDownEnable;
    end

    // pins 1 and 11 serve the registers in registered mode
    // and act as plain array inputs otherwise
    assign next_arrayIn[DED_PINS-1:0]     = dedSync;
    assign next_arrayIn[ARRAY_PIN1_BIT]   = clockSync;
    assign next_arrayIn[ARRAY_PIN11_BIT]  = oeSyncN;
    assign next_arrayValid[DED_PINS-1:0]  = dedValid;
    assign next_arrayValid[ARRAY_PIN1_BIT]  = (modeSel != MODE_REGISTERED);
    assign next_arrayValid[ARRAY_PIN11_BIT] = (modeSel != MODE_REGISTERED);

    // pins and array inputs freeze while powered down
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            ioPinOut     <= '1;
            ioPinOe      <= '0;
            arrayIn      <= '0;
            arrayInValid <= '0;
        end
        else if (!powerDownActive)
        begin
            for (int i = 0; i < CELLS; i++)
            begin
                ioPinOut[i] <= next_cell[i].drive;
                ioPinOe[i]  <= next_cell[i].enable;
            end
            arrayIn      <= next_arrayIn;
            arrayInValid <= next_arrayValid;
        end
    end

    // address decode on word index; low two bits ignored
    assign writeHit    = awready & awvalid & wvalid;
    assign writeMapped = awaddr[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2]
                      || awaddr[ADDR_W-1:2] == CELL_CFG_OFFSET[ADDR_W-1:2]
                      || awaddr[ADDR_W-1:2] == STATUS_OFFSET[ADDR_W-1:2];
    assign readMapped  = araddr[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2]
                      || araddr[ADDR_W-1:2] == CELL_CFG_OFFSET[ADDR_W-1:2]
                      || araddr[ADDR_W-1:2] == STATUS_OFFSET[ADDR_W-1:2];

    // write channel: ready one cycle after both arrive, response after that
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
        end
        else if (awready)
        begin
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= writeMapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bvalid)
        begin
            if (bready)
                bvalid <= 1'b0;
        end
        else if (awvalid && wvalid)
        begin
            awready <= 1'b1;
            wready  <= 1'b1;
        end
    end

    // configuration registers; status writes are accepted and dropped
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            modeBits <= MODE_RESET;
            powerDownEnable <= 1'b0;
            cellCfg  <= CELL_CFG_RESET;
        end
        else if (writeHit)
        begin
            if (awaddr[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2] && wstrb[0])
            begin
                modeBits <= wdata[CTRL_MODE_LSB +: 2];
                powerDownEnable <= wdata[CTRL_POWER_DOWN_BIT];
            end
            if (awaddr[ADDR_W-1:2] == CELL_CFG_OFFSET[ADDR_W-1:2])
            begin
                if (wstrb[0])
                    cellCfg[7:0] <= wdata[7:0];
                if (wstrb[1])
                    cellCfg[15:8] <= wdata[15:8];
            end
        end
    end

    // read mux
    always_comb
    begin
        readValue = '0;
        if (araddr[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2])
        begin
            readValue[CTRL_MODE_LSB +: 2] = modeBits;
            readValue[CTRL_POWER_DOWN_BIT] = powerDownEnable;
        end
        else if (araddr[ADDR_W-1:2] == CELL_CFG_OFFSET[ADDR_W-1:2])
            readValue[CFG_W*CELLS-1:0] = cellCfg;
        else if (araddr[ADDR_W-1:2] == STATUS_OFFSET[ADDR_W-1:2])
        begin
            readValue[CELLS-1:0]                  = regQ;
            readValue[STATUS_POWER_DOWN_BIT]      = powerDownActive;
            readValue[STATUS_OE_LSB +: CELLS]     = ioPinOe;
        end
    end

    // read channel: one cycle to accept, data the cycle after
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OKAY;
        end
        else if (arready)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= readValue;
            rresp   <= readMapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid)
        begin
            if (rready)
                rvalid <= 1'b0;
        end
        else if (arvalid)
            arready <= 1'b1;
    end

    generate
        for (k = 0; k < CELLS; k++)
        begin : g_check
            localparam logic CENTRE = (k == CENTRE_LO_CELL) || (k == CENTRE_HI_CELL);
            localparam logic OUTER  = (k == OUTER_LO_CELL) || (k == OUTER_HI_CELL);

            a_reg_capture: assert property (
                !powerDownActive && clockRise && modeSel == MODE_REGISTERED
                && cellSel[k] == CELL_REGISTERED |=> regQ[k] == $past(|productTerms[k]))
                else $error("register missed clock pin edge");
            a_reg_common_oe: assert property (
                !powerDownActive && modeSel == MODE_REGISTERED && cellSel[k] == CELL_REGISTERED
                |=> ioPinOe[k] == !$past(oeSyncN) && ioPinOut[k] == !$past(regQ[k]))
                else $error("registered cell not on common enable");
            a_comb_term_oe: assert property (
                !powerDownActive && modeSel == MODE_REGISTERED
                && cellSel[k] == CELL_COMBINATORIAL
                |=> ioPinOe[k] == $past(productTerms[k][0])
                    && ioPinOut[k] == $past(|productTerms[k][PTERMS-1:1]))
                else $error("combinatorial cell wrong terms");
            a_input_driver_off: assert property (
                !powerDownActive && cellSel[k] == CELL_INPUT
                && !(modeSel == MODE_SIMPLE && CENTRE) && !(modeSel == MODE_COMPLEX && OUTER)
                |=> !ioPinOe[k])
                else $error("input cell drives its pin");
            a_simple_centre: assert property (
                !powerDownActive && modeSel == MODE_SIMPLE && CENTRE
                |=> ioPinOe[k] && !arrayInValid[ARRAY_FB_LSB + k])
                else $error("centre cell not a plain output");
            a_complex_outer: assert property (
                !powerDownActive && modeSel == MODE_COMPLEX && OUTER
                |=> !arrayInValid[ARRAY_FB_LSB + k])
                else $error("outer cell feeds the array");
            a_simple_sum: assert property (
                !powerDownActive && modeSel == MODE_SIMPLE
                |=> ioPinOut[k] == $past(|productTerms[k]))
                else $error("simple cell sum wrong");
        end
    endgenerate

    a_power_down_hold: assert property (
        powerDownActive |=> $stable(ioPinOut) && $stable(ioPinOe)
                            && $stable(regQ) && $stable(arrayIn))
        else $error("state moved during power-down");
    a_power_down_masked: assert property (
        powerDownEnable && !powerDownActive |=> !arrayInValid[POWER_DOWN_PIN_BIT])
        else $error("power-down pin still an array input");
    a_pin1_dedicated: assert property (
        !powerDownActive && modeSel == MODE_REGISTERED
        |=> !arrayInValid[ARRAY_PIN1_BIT] && !arrayInValid[ARRAY_PIN11_BIT])
        else $error("clock or enable pin reached the array");
    a_pin1_input: assert property (
        !powerDownActive && modeSel != MODE_REGISTERED
        |=> arrayInValid[ARRAY_PIN1_BIT] && arrayIn[ARRAY_PIN1_BIT] == $past(clockSync))
        else $error("pin 1 not an array input");
    a_reset_clear: assert property (@(posedge clock) disable iff (1'b0)
        !nrst |=> regQ == '0 && ioPinOut == '1)
        else $error("reset did not clear registers");

    c_power_down_entry: cover property (!powerDownActive ##1 powerDownActive);
    c_reg_capture: cover property (clockRise && modeSel == MODE_REGISTERED && !powerDownActive);
    c_complex_drive: cover property (modeSel == MODE_COMPLEX && ioPinOe != '0);
    c_simple_mode: cover property (modeSel == MODE_SIMPLE ##1 ioPinOe != '0);
endmodule
`default_nettype wire

/* verif/mcma_board_model.sv */
// board-side model: clock pin pulses and resolved io pin levels
`timescale 1ns/1ps
`default_nettype none
module mcma_board_model
(
    // system side
    input  wire logic       clock,
    input  wire logic       clkReq,
    input  wire logic [7:0] extLevel,
    // device pins
    input  wire logic [7:0] ioPinOut,
    input  wire logic [7:0] ioPinOe,
    output logic            clockPin,
    output logic [7:0]      ioPinIn
);
    logic [2:0] hold = 3'h0;
    // pin stands low between pulses; a pulse lasts four cycles, long enough to sync
    always_ff @(posedge clock)
    begin
        hold <= clkReq ? 3'h4 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
    end
    assign clockPin = (hold != 3'h0);
    // a pin the cell drives shows the cell value, otherwise the board level
    assign ioPinIn = (ioPinOe & ioPinOut) | (~ioPinOe & extLevel);
endmodule
`default_nettype wire

/* verif/mcma_macrocell_array_bench.sv */
// self-checking bench for the macrocell mode array
`timescale 1ns/1ps
`default_nettype none
module mcma_macrocell_array_bench;
    import mcma_pkg::*;
    logic                         clock = 1'b0, nrst = 1'b0, clkReq = 1'b0, oeN = 1'b1;
    logic                         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic                         arvalid = 1'b0, rready = 1'b0;
    logic                         awready, wready, bvalid, arready, rvalid, clockPin;
    logic [ADDR_W-1:0]            awaddr = 4'h0, araddr = 4'h0;
    logic [DATA_W-1:0]            wdata = 32'h0, rdata;
    logic [1:0]                   bresp, rresp;
    logic [7:0]                   ded = 8'h0, ext = 8'h0, pinIn, pinOut, pinOe;
    logic [CELLS-1:0][PTERMS-1:0] terms = '0;
    logic [ARRAY_W-1:0]           arr, arrV;
    logic [1:0]                   wrQ[$];
    logic [33:0]                  rdQ[$];
    int                           error_cnt = 0, checked = 0;

    // 100 MHz system clock
    initial
    begin
        forever #5 clock = ~clock;
    end

    mcma_macrocell_array i_dut
    (
        .clock(clock), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .clockPin(clockPin), .outputEnablePinN(oeN), .dedicatedPins(ded), .ioPinIn(pinIn),
        .ioPinOut(pinOut), .ioPinOe(pinOe), .productTerms(terms), .arrayIn(arr),
        .arrayInValid(arrV)
    );

    mcma_board_model i_board
    (
        .clock(clock), .clkReq(clkReq), .extLevel(ext), .ioPinOut(pinOut),
        .ioPinOe(pinOe), .clockPin(clockPin), .ioPinIn(pinIn)
    );

    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task summarize;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // address and data offered together, both released once awready is seen
    task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        wrQ.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge clock); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge clock); while (bvalid !== 1'b1);
        bready <= 1'b0;
        @(posedge clock);
    endtask

    task automatic axiRead(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        rdQ.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clock); while (rvalid !== 1'b1);
        rready <= 1'b0;
        @(posedge clock);
    endtask

    // pins need three edges to reach the outputs; six leaves margin
    task settle;
        repeat (6) @(posedge clock);
    endtask

    // or of each cell's terms from bit lo upward
    function automatic logic [7:0] sums(input int lo);
        for (int k = 0; k < CELLS; k++)
            sums[k] = |(terms[k] >> lo);
    endfunction

    function automatic logic [7:0] t0();
        for (int k = 0; k < CELLS; k++)
            t0[k] = terms[k][0];
    endfunction

    // bus answers are compared against the oldest note when they appear
    always @(posedge clock)
    begin
        if (bvalid === 1'b1 && bready === 1'b1)
            check(34'(bresp), 34'(wrQ.pop_front()));
        if (rvalid === 1'b1 && rready === 1'b1)
            check({rresp, rdata}, rdQ.pop_front());
    end

    // a hang counts as a mismatch
    initial
    begin
        repeat (3000) @(posedge clock);
        error_cnt++;
        $display("BAD %0t: timeout", $time);
        summarize();
    end

    // main sequence
    initial
    begin
        logic       r0;
        logic [15:0] exp;
        void'($urandom(26));
        repeat (8) @(posedge clock);
        // input cells drive nothing meaningful after reset, so pin levels are taken in reset
        check(34'({pinOut, pinOe}), 34'({8'hff, 8'h00}));
        nrst <= 1'b1;
        terms <= '1;
        settle();
        check(34'({pinOe, arrV}), 34'({8'h00, 18'h3fcff}));
        axiRead(CTRL_OFFSET, 32'h0, RESP_OKAY);
        axiRead(CELL_CFG_OFFSET, 32'h0000aaaa, RESP_OKAY);
        axiWrite(STATUS_OFFSET, 32'hffffffff, RESP_OKAY);
        axiRead(STATUS_OFFSET, 32'h0, RESP_OKAY);
        axiWrite(4'hc, 32'h1, RESP_SLVERR);
        axiRead(4'hc, 32'h0, RESP_SLVERR);
        // registered mode, cell 0 registered, cell 1 combinatorial, rest inputs
        terms <= {$urandom(), $urandom()};
        ded <= 8'($urandom());
        ext <= 8'($urandom());
        oeN <= 1'b0;
        axiWrite(CTRL_OFFSET, 32'h0, RESP_OKAY);
        axiWrite(CELL_CFG_OFFSET, 32'h0000aaa4, RESP_OKAY);
        clkReq <= 1'b1;
        @(posedge clock);
        clkReq <= 1'b0;
        r0 = |terms[0];
        settle();
        check(34'({pinOut[1:0], pinOe}), 34'({|terms[1][7:1], ~r0, 6'h0, terms[1][0], 1'b1}));
        check(34'({arrV[9:0], arr[7:0]}), 34'({10'h0ff, ded}));
        terms <= ~terms;
        oeN <= 1'b1;
        settle();
        check(34'({pinOut[0], pinOe[0]}), 34'({~r0, 1'b0}));
        // complex mode, all cells combinatorial
        axiWrite(CELL_CFG_OFFSET, 32'h00005555, RESP_OKAY);
        axiWrite(CTRL_OFFSET, 32'h1, RESP_OKAY);
        terms <= {$urandom(), $urandom()};
        settle();
        check(34'({pinOut, pinOe}), 34'({sums(1), t0()}));
        check(34'(arrV), 34'(18'h1fbff));
        check(34'({arr[9:8], arr[16:11]}), 34'({oeN, clockPin, pinIn[6:1]}));
        // simple mode
        ded[2] <= 1'b0;
        axiWrite(CTRL_OFFSET, 32'h2, RESP_OKAY);
        settle();
        check(34'({pinOut, pinOe}), 34'({sums(0), 8'hff}));
        check(34'(arrV), 34'(18'h39fff));
        // power-down enabled, control low, then high
        axiWrite(CTRL_OFFSET, 32'h12, RESP_OKAY);
        settle();
        check(34'(arrV), 34'(18'h39ffb));
        ded[2] <= 1'b1;
        exp = {sums(0), 8'hff};
        settle();
        terms <= ~terms;
        ded <= ~ded | 8'h04;
        settle();
        check(34'({pinOut, pinOe}), 34'(exp));
        // bus stays alive while frozen; register 0 still holds its captured sum
        axiRead(STATUS_OFFSET, {8'h0, 8'hff, 7'h0, 1'b1, 7'h0, r0}, RESP_OKAY);
        // second reset mid-run
        nrst <= 1'b0;
        repeat (3) @(posedge clock);
        check(34'({pinOut, pinOe}), 34'({8'hff, 8'h00}));
        nrst <= 1'b1;
        settle();
        check(34'({pinOe, arrV}), 34'({8'h00, 18'h3fcff}));
        axiRead(CTRL_OFFSET, 32'h0, RESP_OKAY);
        // spare mode code must behave as registered
        axiWrite(CTRL_OFFSET, 32'h3, RESP_OKAY);
        axiRead(CTRL_OFFSET, 32'h3, RESP_OKAY);
        settle();
        check(34'(arrV[9:8]), 34'(2'h0));
        summarize();
    end
endmodule
`default_nettype wire
